// ---- rtl/nuid_host.sv ----
/*
  Host controller that reads the unique identifier of a NAND target: sends
  the read-unique-ID command and address, waits out the busy time by the
  ready pin or by status polling, optionally jumps to a chosen copy, then
  reads and checks copies in turn until one is good or copy 15 fails.
  Assumes the NAND pins are asynchronous to CLOCK_I; the bidirectional data
  wire is resolved outside from DQ_O and DQ_OE_O.
*/
`timescale 1ns/1ns
module nuid_host
  import nuid_pkg::*;
#(
  parameter int DQ_W = 8
) (
  // Clock, reset, enable
  input  wire logic              CLOCK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              CLK_EN_I,
  // User request
  input  wire logic              START_I,
  input  wire logic              POLL_I,
  input  wire logic [COPY_W-1:0] COPY_I,
  output logic                   BUSY_O,
  output logic                   DONE_O,
  output logic                   OK_O,
  output logic                   ERR_O,
  // Identifier read-out
  input  wire logic [3:0]        ID_ADDR_I,
  output logic      [7:0]        ID_DATA_O,
  // NAND pins
  output logic                   CE_N_O,
  output logic                   CLE_O,
  output logic                   ALE_O,
  output logic                   WE_N_O,
  output logic                   RE_N_O,
  output logic      [DQ_W-1:0]   DQ_O,
  output logic                   DQ_OE_O,
  input  wire logic [DQ_W-1:0]   DQ_I,
  input  wire logic              RDY_I
);

  nuid_phase_t ph, next_ph;
  logic [CNT_W-1:0]      cnt, next_cnt;
  logic [TMO_W-1:0]      tmo, next_tmo;
  logic [COPY_W-1:0]     copy, next_copy;
  logic [BYTE_IDX_W-1:0] bidx, next_bidx;
  logic                  bad, next_bad;
  logic                  ok_end, next_ok_end;
  logic [DQ_W-1:0]       dq_m, dq_s;
  logic                  rdy_m, rdy_s;
  logic [7:0]            half_rd;

  // Two-flop synchronisers for the pins
  always_ff @(posedge CLOCK_I) begin
    if (CLK_EN_I) begin
      dq_m  <= DQ_I;
      dq_s  <= dq_m;
      rdy_m <= RDY_I;
      rdy_s <= rdy_m;
    end
  end

  // Phase decoding
  wire       wr_ph   = ph inside {PH_CMD, PH_ADDR, PH_STAT_CMD, PH_MODE_CMD,
                                  PH_RND_CMD, PH_COL_LO, PH_COL_HI, PH_RND_END};
  wire       rd_ph   = (ph == PH_STAT_RD) || (ph == PH_DATA);
  wire       is_addr = (ph == PH_ADDR) || (ph == PH_COL_LO) || (ph == PH_COL_HI);
  wire       wr_last = wr_ph && (cnt == CNT_W'(WR_CYC - 1));
  wire       rd_last = rd_ph && (cnt == CNT_W'(RD_CYC - 1));
  wire       sample  = rd_ph && (cnt == CNT_W'(RE_LOW_CYC - 1));
  wire       we_low  = wr_ph && (cnt < CNT_W'(WE_LOW_CYC));
  wire       re_low  = rd_ph && (cnt < CNT_W'(RE_LOW_CYC));
  wire [7:0] rx_byte = dq_s[7:0];
  wire       rx_rdy  = rx_byte[STATUS_RDY_BIT];
  wire       in_hi   = bidx[BYTE_IDX_W-1];
  wire       xor_ok  = ((rx_byte ^ half_rd) == ALL_ONES);
  wire       tmo_hit = (tmo >= TMO_W'(BUSY_TMO_CYC)); // Poll rounds may step past the limit
  wire       start   = START_I && (ph == PH_IDLE);
  wire       mem_wr  = (ph == PH_DATA) && sample && !in_hi;
  wire [7:0] col_lo  = {copy[2:0], 5'h00};
  wire [7:0] col_hi  = {7'h00, copy[COPY_W-1]};

  // Byte put on the data lines for each write phase
  logic [7:0] tx_byte;
  always_comb begin
    unique case (ph)
      PH_CMD:      tx_byte = CMD_READ_UID;
      PH_ADDR:     tx_byte = ADDR_UID;
      PH_STAT_CMD: tx_byte = CMD_READ_STATUS;
      PH_MODE_CMD: tx_byte = CMD_READ_MODE;
      PH_RND_CMD:  tx_byte = CMD_RND_READ;
      PH_COL_LO:   tx_byte = col_lo;
      PH_COL_HI:   tx_byte = col_hi;
      PH_RND_END:  tx_byte = CMD_RND_CONFIRM;
      default:     tx_byte = 8'h00;
    endcase
  end

  // Sequencer next state
  always_comb begin
    next_ph     = ph;
    next_cnt    = cnt + CNT_W'(1);
    next_tmo    = tmo;
    next_copy   = copy;
    next_bidx   = bidx;
    next_bad    = bad;
    next_ok_end = ok_end;
    unique case (ph)
      PH_IDLE: begin
        next_cnt = '0;
        if (START_I) begin
          next_copy   = COPY_I;
          next_bidx   = '0;
          next_bad    = 1'b0;
          next_ok_end = 1'b0;
          next_ph     = rdy_s ? PH_CMD : PH_END;
        end
      end
      PH_WAIT: begin
        next_tmo = tmo + TMO_W'(1);
        if (tmo_hit) begin
          next_ph = PH_END;
        end else if (cnt >= CNT_W'(WB_CYC)) begin
          next_cnt = cnt;
          if (POLL_I) begin
            next_ph  = PH_STAT_CMD;
            next_cnt = '0;
          end else if (rdy_s) begin
            next_ph  = (copy != '0) ? PH_RND_CMD : PH_GAP;
            next_cnt = '0;
          end
        end
      end
      PH_STAT_RD: begin
        next_tmo = tmo + TMO_W'(1);
        if (rd_last) begin
          next_cnt = '0;
          if (rx_rdy) next_ph = PH_MODE_CMD;
          else if (tmo_hit) next_ph = PH_END;
        end
      end
      PH_GAP: begin
        if (cnt == CNT_W'(WHR_CYC - 1)) begin
          next_ph  = PH_DATA;
          next_cnt = '0;
        end
      end
      PH_DATA: begin
        if (sample && in_hi && !xor_ok) next_bad = 1'b1;
        if (rd_last) begin
          next_cnt  = '0;
          next_bidx = bidx + BYTE_IDX_W'(1);
          if (bidx == BYTE_IDX_W'(UID_COPY_LEN - 1)) begin
            if (!bad) begin
              next_ok_end = 1'b1;
              next_ph     = PH_END;
            end else if (copy == COPY_W'(UID_COPIES - 1)) begin
              next_ph = PH_END;
            end else begin
              next_copy = copy + COPY_W'(1);
              next_bad  = 1'b0;
            end
          end
        end
      end
      PH_END: begin
        next_ph  = PH_IDLE;
        next_cnt = '0;
      end
      default: begin
        if (wr_last) begin
          next_cnt = '0;
          unique case (ph)
            PH_CMD:      next_ph = PH_ADDR;
            PH_ADDR:     next_ph = PH_WAIT;
            PH_STAT_CMD: next_ph = PH_STAT_RD;
            PH_MODE_CMD: next_ph = (copy != '0) ? PH_RND_CMD : PH_GAP;
            PH_RND_CMD:  next_ph = PH_COL_LO;
            PH_COL_LO:   next_ph = PH_COL_HI;
            PH_COL_HI:   next_ph = PH_RND_END;
            default:     next_ph = PH_GAP;
          endcase
        end
        if (ph == PH_ADDR) next_tmo = '0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      ph <= PH_IDLE; cnt <= '0; tmo <= '0; copy <= '0;
      bidx <= '0; bad <= 1'b0; ok_end <= 1'b0;
    end else if (CLK_EN_I) begin
      ph <= next_ph; cnt <= next_cnt; tmo <= next_tmo; copy <= next_copy;
      bidx <= next_bidx; bad <= next_bad; ok_end <= next_ok_end;
    end
  end

  // Registered pins and user status
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      CE_N_O <= 1'b1; CLE_O <= 1'b0; ALE_O <= 1'b0; WE_N_O <= 1'b1;
      RE_N_O <= 1'b1; DQ_O <= '0; DQ_OE_O <= 1'b0;
      BUSY_O <= 1'b0; DONE_O <= 1'b0; OK_O <= 1'b0; ERR_O <= 1'b0;
    end else if (CLK_EN_I) begin
      CE_N_O  <= (next_ph == PH_IDLE) || (next_ph == PH_END);
      CLE_O   <= wr_ph && !is_addr;
      ALE_O   <= wr_ph && is_addr;
      WE_N_O  <= !we_low;
      RE_N_O  <= !re_low;
      DQ_O    <= DQ_W'(tx_byte);
      DQ_OE_O <= wr_ph;
      BUSY_O  <= (next_ph != PH_IDLE);
      DONE_O  <= (ph == PH_END);
      if (start) begin
        OK_O  <= 1'b0;
        ERR_O <= 1'b0;
      end else if (ph == PH_END) begin
        OK_O  <= ok_end;
        ERR_O <= !ok_end;
      end
    end
  end

  // First half of the current copy, checked against the second half
  nuid_id_mem #(.WIDTH(8), .DEPTH(UID_HALF), .AW(4)) u_mem (
    .clk_i       (CLOCK_I),
    .clk_en_i    (CLK_EN_I),
    .wr_en_i     (mem_wr),
    .wr_addr_i   (bidx[3:0]),
    .wr_data_i   (rx_byte),
    .rd_a_addr_i (bidx[3:0]),
    .rd_a_data_o (half_rd),
    .rd_b_addr_i (ID_ADDR_I),
    .rd_b_data_o (ID_DATA_O)
  );

  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I || !CLK_EN_I);

  chk_cmd_when_idle: assert property ((ph == PH_IDLE && START_I && !rdy_s)
    |=> ph == PH_END) else $error("command issued while target busy");
  chk_addr_after_cmd: assert property ((ph == PH_CMD && wr_last)
    |=> ph == PH_ADDR ##1 (ALE_O && DQ_O[7:0] == ADDR_UID)) else $error("bad address cycle");
  chk_mode_after_poll: assert property ((ph == PH_STAT_RD && rd_last && rx_rdy)
    |=> ph == PH_MODE_CMD) else $error("read mode not restored");
  chk_no_read_busy: assert property ((ph == PH_WAIT && !POLL_I && !rdy_s)
    |=> (ph == PH_WAIT || ph == PH_END)) else $error("data read started while target busy");
  chk_no_strobe_clash: assert property (!(!WE_N_O && !RE_N_O))
    else $error("write and read strobes together");
  chk_rnd_order: assert property ((ph == PH_RND_CMD && wr_last)
    |=> ph == PH_COL_LO [*2] ##1 ph == PH_COL_HI [*2] ##1 ph == PH_RND_END)
    else $error("random read order broken");
  chk_ok_clean: assert property ((ph == PH_END && ok_end) |-> !bad)
    else $error("copy accepted after failed compare");
  chk_copy_step: assert property ((ph == PH_DATA && rd_last && bad
    && bidx == BYTE_IDX_W'(UID_COPY_LEN - 1) && copy != COPY_W'(UID_COPIES - 1))
    |=> copy == $past(copy) + COPY_W'(1)) else $error("copy not advanced");
  chk_done_pulse: assert property (DONE_O |=> !DONE_O)
    else $error("done longer than one cycle");

  cov_good_first: cover property (ph == PH_END && ok_end && copy == '0);
  cov_retry_copy: cover property (ph == PH_DATA && copy != '0 && bidx == '0);
  cov_poll_path: cover property (ph == PH_MODE_CMD);
  cov_jump_copy: cover property (ph == PH_RND_END);

endmodule : nuid_host

// ---- rtl/nuid_pkg.sv ----
/*
  Constants for the host controller that reads the unique identifier of a
  NAND target over its asynchronous pins: command codes, pin timing, the
  identifier layout and the timing fields that the target reports.
  Assumes one 20 MHz system clock and an asynchronous NAND interface.
*/
// Functional notes
// - Unique-ID command only while all dies idle; host issues it only then.
// - Host sends one address cycle 00h; target then busy for array_read_time.
// - After polling with 70h, host sends 00h before reading identifier data.
// - Host XORs the halves; copy good only if all sixteen give FFh.
// - Random data read 05h then E0h moves the output position.
package nuid_pkg;

  // Command and address bytes
  localparam logic [7:0] CMD_READ_UID    = 8'hED;
  localparam logic [7:0] ADDR_UID        = 8'h00;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_MODE   = 8'h00;
  localparam logic [7:0] CMD_RND_READ    = 8'h05;
  localparam logic [7:0] CMD_RND_CONFIRM = 8'hE0;
  localparam int         STATUS_RDY_BIT  = 6;
  localparam logic [7:0] ALL_ONES        = 8'hFF;

  // Identifier layout
  localparam int UID_COPIES    = 16;
  localparam int UID_HALF      = 16;
  localparam int UID_COPY_LEN  = 32;
  localparam int COPY_W        = 4;
  localparam int BYTE_IDX_W    = 5;

  // Timing fields reported in the parameter page, low byte first
  localparam int         PP_PROG_OFS   = 133;
  localparam logic [7:0] PP_PROG_LO    = 8'h58;
  localparam logic [7:0] PP_PROG_HI    = 8'h02;
  localparam int         PP_ERASE_OFS  = 135;
  localparam logic [7:0] PP_ERASE_LO   = 8'h10;
  localparam logic [7:0] PP_ERASE_HI   = 8'h27;
  localparam int         PP_READ_OFS   = 137;
  localparam logic [7:0] PP_READ_LO    = 8'h19;
  localparam logic [7:0] PP_READ_HI    = 8'h00;
  localparam int         PP_COPY_LEN   = 256;
  localparam int         PP_COPY2_OFS  = 256;
  localparam int         PP_COPY3_OFS  = 512;
  localparam int         PP_EXTRA_OFS  = 768;

  // Worst-case times in microseconds, as the target reports them
  localparam int PAGE_PROGRAM_TIME_US = {PP_PROG_HI, PP_PROG_LO};
  localparam int BLOCK_ERASE_TIME_US  = {PP_ERASE_HI, PP_ERASE_LO};
  localparam int ARRAY_READ_TIME_US   = {PP_READ_HI, PP_READ_LO};

  // Pin timing in ns; least times round up, none below one cycle
  localparam int T_CLK_NS   = 50;
  localparam int WE_LOW_NS  = 25;
  localparam int WE_HIGH_NS = 15;
  localparam int REA_NS     = 25;
  localparam int RE_HIGH_NS = 15;
  localparam int WB_NS      = 100;
  localparam int WHR_NS     = 80;
  localparam int SYNC_DEPTH = 2;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + T_CLK_NS - 1) / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int WE_LOW_CYC  = ns_to_cyc(WE_LOW_NS);
  localparam int WR_CYC      = WE_LOW_CYC + ns_to_cyc(WE_HIGH_NS);
  localparam int RE_LOW_CYC  = ns_to_cyc(REA_NS) + SYNC_DEPTH + 1;
  localparam int RD_CYC      = RE_LOW_CYC + ns_to_cyc(RE_HIGH_NS);
  localparam int WB_CYC      = ns_to_cyc(WB_NS);
  localparam int WHR_CYC     = ns_to_cyc(WHR_NS);
  localparam int BUSY_TMO_CYC = WB_CYC + (ARRAY_READ_TIME_US * 1000) / T_CLK_NS;
  localparam int CNT_W       = 4;
  localparam int TMO_W       = $clog2(BUSY_TMO_CYC + 1);

  // Sequencer phases
  typedef enum logic [3:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_WAIT, PH_STAT_CMD, PH_STAT_RD, PH_MODE_CMD,
    PH_RND_CMD, PH_COL_LO, PH_COL_HI, PH_RND_END, PH_GAP, PH_DATA, PH_END
  } nuid_phase_t;

endpackage : nuid_pkg

// ---- rtl/nuid_id_mem.sv ----
/*
  Small buffer holding the first half of an identifier copy, with one write
  port and two read ports whose data come out of registers.
  Assumes the owner keeps write and read addresses in range.
*/
`timescale 1ns/1ns
module nuid_id_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock, enable
  input  wire logic             clk_i,
  input  wire logic             clk_en_i,
  // Write port
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read ports
  input  wire logic [AW-1:0]    rd_a_addr_i,
  output logic      [WIDTH-1:0] rd_a_data_o,
  input  wire logic [AW-1:0]    rd_b_addr_i,
  output logic      [WIDTH-1:0] rd_b_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage and registered reads
  always_ff @(posedge clk_i) begin
    if (clk_en_i) begin
      if (wr_en_i) mem[wr_addr_i] <= wr_data_i;
      rd_a_data_o <= mem[rd_a_addr_i];
      rd_b_data_o <= mem[rd_b_addr_i];
    end
  end

endmodule : nuid_id_mem

// ---- verif/nuid_nand_model.sv ----
/*
  Behavioural NAND target for the unique-ID read: command and address
  latching, busy time, status, random data read, sixteen 32-byte copies.
  Assumes an 8-bit bus resolved by the bench; no parameter page output.
*/
`timescale 1ns/1ns
module nuid_nand_model (
  // Host pins
  input  wire logic        ce_n_i,
  input  wire logic        cle_i,
  input  wire logic        ale_i,
  input  wire logic        we_n_i,
  input  wire logic        re_n_i,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             rdy_o,
  // Bench controls
  input  wire logic [31:0] busy_ns_i,
  input  wire logic [15:0] bad_copy_i,
  input  wire logic        hold_busy_i,
  output int               early_reads_o
);
  logic       busy = 1'b0;
  logic       uid_mode = 1'b0;
  logic       stat_mode = 1'b0;
  logic [8:0] pos = '0;
  logic [15:0] col = '0;
  int         acol = 2;
  event       go_busy;

  initial dq_o = 8'hFF;
  initial early_reads_o = 0;
  assign rdy_o = ~(busy | hold_busy_i);

  // Identifier byte, complement half, and a wrong byte in bad copies
  function automatic logic [7:0] uid_at(input logic [8:0] p, input logic [15:0] bad);
    logic [3:0] b;
    b = p[3:0];
    if (!p[4]) return {b, ~b};
    if (bad[p[8:5]] && b == 4'h3) return {~b, b} ^ 8'h01;
    return {~b, b};
  endfunction : uid_at

  // Latch commands and addresses on the write strobe rising edge
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i && (!busy || dq_i == 8'h70)) begin
      stat_mode = (dq_i == 8'h70);
      if (dq_i == 8'hED) uid_mode = 1'b1;
      if (dq_i == 8'h05) acol = 0;
      if (dq_i == 8'hE0) pos = col[8:0];
      if (!(dq_i inside {8'hED, 8'h00, 8'h70, 8'h05, 8'hE0})) uid_mode = 1'b0;
    end else if (!ce_n_i && ale_i && !busy) begin
      if (acol == 0) col[7:0] = dq_i;
      if (acol == 1) col[15:8] = dq_i;
      if (acol == 2 && uid_mode && dq_i == 8'h00) begin
        pos = '0;
        -> go_busy;
      end
      if (acol < 2) acol++;
    end
  end

  // Busy for the array read time after the address cycle
  always @(go_busy) begin
    #40 busy = 1'b1;
    #(busy_ns_i) busy = 1'b0;
  end

  // One byte per read strobe, bus released to inverse afterwards
  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      if (busy && !stat_mode) early_reads_o++;
      #20 dq_o = stat_mode ? {1'b0, rdy_o, 6'h00} : uid_at(pos, bad_copy_i);
    end
  end
  always @(posedge re_n_i) begin
    if (!ce_n_i && uid_mode && !stat_mode) pos = pos + 9'h001;
    #30 dq_o = ~dq_o;
  end
endmodule : nuid_nand_model

// ---- verif/tb_nuid_host.sv ----
/*
  Self-checking bench for the unique-ID host controller: reported timing
  fields, plain, frozen, polled, jump, bad-copy, refused and timed-out reads
  against the target model.
  Assumes a 16-bit host bus whose upper lines carry junk from the target.
*/
`timescale 1ns/1ns
module tb_nuid_host;
  import nuid_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        poll = 1'b0;
  logic [3:0]  copy = '0;
  logic [3:0]  id_addr = '0;
  logic        busy_o, done, ok, err, ce_n, cle, ale, we_n, re_n, oe, rdy, hold = 1'b0;
  logic        en = 1'b1;
  logic [7:0]  id_data, dq_dev;
  logic [15:0] dq_h, dq_bus;
  logic [31:0] busy_ns = 32'h00000BB8;
  logic [15:0] bad = '0;
  logic [8:0]  log_q[$];
  int          early, n_reads, hi_nz = 0, mismatches = 0, n_compared = 0;
  logic        r_ok, r_err;

  assign dq_bus = oe ? dq_h : {8'hA5, dq_dev};
  initial forever #25 clk = ~clk;

  nuid_host #(.DQ_W(16)) i_dut (.CLOCK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en), .START_I(start),
    .POLL_I(poll), .COPY_I(copy), .BUSY_O(busy_o), .DONE_O(done), .OK_O(ok), .ERR_O(err),
    .ID_ADDR_I(id_addr), .ID_DATA_O(id_data), .CE_N_O(ce_n), .CLE_O(cle), .ALE_O(ale),
    .WE_N_O(we_n), .RE_N_O(re_n), .DQ_O(dq_h), .DQ_OE_O(oe), .DQ_I(dq_bus), .RDY_I(rdy));
  nuid_nand_model i_nand (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .re_n_i(re_n), .dq_i(dq_bus[7:0]), .dq_o(dq_dev), .rdy_o(rdy), .busy_ns_i(busy_ns),
    .bad_copy_i(bad), .hold_busy_i(hold), .early_reads_o(early));

  // Record written bytes, address flag on top, and count read strobes
  always @(posedge we_n) if (!ce_n) begin
    log_q.push_back({ale, dq_bus[7:0]});
    if (dq_bus[15:8] !== 8'h00) hi_nz++;
  end
  always @(negedge re_n) if (!ce_n) n_reads++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // One operation from start to the done pulse
  task automatic run(input logic [3:0] c, input logic p);
    int i;
    log_q.delete();
    n_reads = 0;
    @(posedge clk);
    #5 start = 1'b1;
    copy = c;
    poll = p;
    @(posedge clk);
    #5 start = 1'b0;
    check("busy", busy_o, 1'b1);
    i = 0;
    while (done !== 1'b1 && i < 6000) begin
      @(posedge clk);
      #1 i++;
    end
    if (i >= 6000) begin
      mismatches++;
      $display("BAD done never came");
      print_verdict();
    end
    r_ok = ok;
    r_err = err;
    check("busy end", busy_o, 1'b0);
  endtask : run

  task automatic check_id;
    for (int b = 0; b < 16; b++) begin
      @(posedge clk);
      #5 id_addr = b[3:0];
      @(posedge clk);
      #1 check("id byte", id_data, {b[3:0], ~b[3:0]});
    end
  endtask : check_id

  task automatic t_plain;
    run(4'h0, 1'b0);
    check("ok", r_ok, 1'b1);
    check("cmd", log_q[0], 9'h0ED);
    check("addr", log_q[1], 9'h100);
    check("reads", n_reads, 32);
    check("early", early, 0);
    check_id();
    check("upper lines", hi_nz, 0);
  endtask : t_plain

  // Timing fields and copy offsets that the target reports
  task automatic t_param;
    check("prog lo", PP_PROG_LO, 8'h58);
    check("prog hi", PP_PROG_HI, 8'h02);
    check("prog ofs", PP_PROG_OFS, 133);
    check("erase lo", PP_ERASE_LO, 8'h10);
    check("erase hi", PP_ERASE_HI, 8'h27);
    check("erase ofs", PP_ERASE_OFS, 135);
    check("read lo", PP_READ_LO, 8'h19);
    check("read hi", PP_READ_HI, 8'h00);
    check("read ofs", PP_READ_OFS, 137);
    check("busy limit", BUSY_TMO_CYC, 502);
    check("copy 2", PP_COPY2_OFS, 256);
    check("copy 3", PP_COPY3_OFS, 512);
    check("extra", PP_EXTRA_OFS, 768);
  endtask : t_param

  // Plain read with the clock enable dropped for ten cycles mid data
  task automatic t_freeze;
    int n;
    fork
      run(4'h0, 1'b0);
      begin
        repeat (100) @(posedge clk);
        #5 en = 1'b0;
        n = n_reads;
        repeat (10) @(posedge clk);
        #5 en = 1'b1;
        check("frozen reads", n_reads, n);
      end
    join
    check("ok", r_ok, 1'b1);
    check("reads", n_reads, 32);
  endtask : t_freeze

  task automatic t_poll;
    run(4'h0, 1'b1);
    check("status cmd", log_q[2], 9'h070);
    check("mode cmd", log_q[log_q.size()-1], 9'h000);
    check("ok", r_ok, 1'b1);
  endtask : t_poll

  task automatic t_jump;
    bad = 16'h001F;
    run(4'h5, 1'b0);
    check("jump cmd", log_q[2], 9'h005);
    check("col lo", log_q[3], 9'h1A0);
    check("col hi", log_q[4], 9'h100);
    check("confirm", log_q[5], 9'h0E0);
    check("reads", n_reads, 32);
    check("ok", r_ok, 1'b1);
    bad = 16'h0200;
    run(4'h9, 1'b0);
    check("jump cmd", log_q[2], 9'h005);
    check("col lo", log_q[3], 9'h120);
    check("col hi", log_q[4], 9'h101);
    check("reads", n_reads, 64);
    check("ok", r_ok, 1'b1);
  endtask : t_jump

  task automatic t_bad;
    bad = 16'h0007;
    run(4'h0, 1'b0);
    check("ok", r_ok, 1'b1);
    check("reads", n_reads, 128);
    check_id();
    bad = 16'hFFFF;
    run(4'h0, 1'b0);
    check("err", r_err, 1'b1);
    check("ok", r_ok, 1'b0);
    check("reads", n_reads, 512);
    bad = '0;
  endtask : t_bad

  task automatic t_refuse;
    @(posedge clk);
    #5 hold = 1'b1;
    repeat (3) @(posedge clk);
    run(4'h0, 1'b0);
    check("err", r_err, 1'b1);
    check("writes", log_q.size(), 0);
    @(posedge clk);
    #5 hold = 1'b0;
    repeat (3) @(posedge clk);
  endtask : t_refuse

  task automatic t_timeout;
    busy_ns = 32'h00009C40;
    run(4'h0, 1'b0);
    check("err", r_err, 1'b1);
    check("early", early, 0);
    repeat (400) @(posedge clk);
    run(4'h0, 1'b1);
    check("poll err", r_err, 1'b1);
    check("status cmd", log_q[2], 9'h070);
  endtask : t_timeout

  // Reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk);
    #5 rst = 1'b0;
    t_param();
    t_plain();
    t_freeze();
    t_poll();
    t_jump();
    t_bad();
    t_refuse();
    t_timeout();
    print_verdict();
  end
endmodule : tb_nuid_host
